// ### rtl/sfsp_consts.svh
`ifndef SFSP_CONSTS_SVH
`define SFSP_CONSTS_SVH
// Contract
// R1: Dual data out: lane1 odd, lane0 even bits.
// R2: Dual address: lane1 odd, lane0 even, sixteen clocks.
// R3: Quad data out: lane n carries n+4, then n.
// R4: Quad address plus mode bits in eight clocks.
// R5: Quad-IO read: four dummy clocks before data.
// R6: Three security registers decoded from address 15:9.
// R7: Volatile enable: next status write updates volatile copy.
// R8: Write-disable clears the write-enable latch.
// R9: Latch cleared at power-up and on completions.
// R10: 05h reads bits 7:0, 35h bits 15:8.
// R11: Host polls busy before new instructions.
// R12: Sixteen status bits in the fixed order.
// R13: Busy reads one during program, erase, status write.
// R14: Latch clear refuses status write, program, erase.
// R15: Block-protect bits written only outside hardware protection.
// R16: Chip erase only when nothing is block-protected.
// R17: Protect mode 00: writable whenever latch set.
// R18: Protect mode 01: locked while protect pin low.
// R19: Protect mode 10: locked until next power cycle.
// R20: Protect mode 11: status permanently unwritable; here reset returns it to mode 00.
// R21: Quad enable turns protect and hold into lanes.
// R22: Lock bits set once, never cleared; here reset clears them.
// R23: Complement bit defaults zero, modifies protected region; here the bit is only stored and has no effect.
// R24: Write-enable opcode sets the latch.
// R25: Status write must end at 8 or 16 bits.
// R26: Status writes never touch suspend, latch, busy bits.
// R27: Status shifted MSB first on lane one only.

`define SFSP_CLK_NS 10
`define SFSP_TW_US 5000
`define SFSP_TW_CYCLES ((`SFSP_TW_US * 1000) / `SFSP_CLK_NS)

`define SFSP_OP_WRITE_ENABLE 8'h06
`define SFSP_OP_WRITE_DISABLE 8'h04
`define SFSP_OP_VOL_ENABLE 8'h50
`define SFSP_OP_STATUS_LO 8'h05
`define SFSP_OP_STATUS_HI 8'h35
`define SFSP_OP_STATUS_WRITE 8'h01
`define SFSP_OP_READ 8'h03
`define SFSP_OP_FAST_READ 8'h0b
`define SFSP_OP_DUAL_OUT 8'h3b
`define SFSP_OP_DUAL_IO 8'hbb
`define SFSP_OP_QUAD_OUT 8'h6b
`define SFSP_OP_QUAD_IO 8'heb
`define SFSP_OP_PAGE_PROG 8'h02
`define SFSP_OP_DUAL_PROG 8'ha2
`define SFSP_OP_QUAD_PROG 8'h32
`define SFSP_OP_PAGE_ERASE 8'h81
`define SFSP_OP_SECTOR_ERASE 8'h20
`define SFSP_OP_BLK32_ERASE 8'h52
`define SFSP_OP_BLK64_ERASE 8'hd8
`define SFSP_OP_CHIP_ERASE_A 8'h60
`define SFSP_OP_CHIP_ERASE_B 8'hc7
`define SFSP_OP_SECURE_ERASE 8'h44
`define SFSP_OP_SECURE_PROG 8'h42
`define SFSP_OP_SUSPEND_A 8'h75
`define SFSP_OP_SUSPEND_B 8'hb0
`define SFSP_OP_RESUME_A 8'h7a
`define SFSP_OP_RESUME_B 8'h30
`define SFSP_OP_RESET_ENABLE 8'h66
`define SFSP_OP_RESET 8'h99

`define SFSP_BIT_BUSY 0
`define SFSP_BIT_LATCH 1
`define SFSP_BIT_PM_LO 7
`define SFSP_BIT_PM_HI 8
`define SFSP_BIT_QUAD 9
`define SFSP_BIT_PROG_SUSP 10
`define SFSP_BIT_COMPLEMENT 14
`define SFSP_BIT_ERASE_SUSP 15
`define SFSP_FLD_BP 6:2
`define SFSP_FLD_LOCK 13:11
`define SFSP_STATUS_RESET 16'h0000
`define SFSP_WMASK_16 16'h7bfc
`define SFSP_WMASK_8 16'h00fc

`define SFSP_SEC_HIGH 8'h00
`define SFSP_SEC_REG1 7'h08
`define SFSP_SEC_REG2 7'h10
`define SFSP_SEC_REG3 7'h18

`define SFSP_CNT_OPCODE 6'h08
`define SFSP_CNT_WR8 6'h10
`define SFSP_CNT_WR16 6'h18
`define SFSP_CNT_ADDR 6'h20
`define SFSP_CNT_MAX 6'h3f
`define SFSP_HDR_STATUS 6'h08
`define SFSP_HDR_READ 6'h20
`define SFSP_HDR_FAST 6'h28
`define SFSP_HDR_DUAL_IO 6'h18
`define SFSP_HDR_QUAD_IO 6'h14
`define SFSP_ADDR_END_2 6'h18
`define SFSP_ADDR_END_4 6'h10
`endif

// ### rtl/sfsp_pkg.sv
package sfsp_pkg;
  typedef enum logic [1:0] {
    sfsp_lane_1 = 2'h0,
    sfsp_lane_2 = 2'h1,
    sfsp_lane_4 = 2'h2
  } sfsp_lanes_t;

  typedef enum logic [1:0] {
    sfsp_idle = 2'h0,
    sfsp_array = 2'h1,
    sfsp_susp = 2'h3,
    sfsp_srw = 2'h2
  } sfsp_state_t;
endpackage

// ### rtl/sfsp_status_protect.sv
`timescale 1ns/1ps
`include "sfsp_consts.svh"

module sfsp_status_protect #(
  parameter int unsigned TW_CYCLES = `SFSP_TW_CYCLES
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  output logic [23:0] array_addr,
  input wire logic [7:0] array_byte,
  output logic op_start,
  output logic [7:0] op_code,
  output logic [23:0] op_addr,
  output logic op_suspend,
  input wire logic op_done,
  output logic [15:0] status_word
);
  import sfsp_pkg::*;

  localparam int TW_W = $clog2(TW_CYCLES + 1);

  function automatic sfsp_lanes_t addr_lanes(input logic [7:0] op);
    case (op)
      `SFSP_OP_DUAL_IO: addr_lanes = sfsp_lane_2;
      `SFSP_OP_QUAD_IO: addr_lanes = sfsp_lane_4;
      default: addr_lanes = sfsp_lane_1;
    endcase
  endfunction

  function automatic sfsp_lanes_t data_lanes(input logic [7:0] op);
    case (op)
      `SFSP_OP_DUAL_OUT, `SFSP_OP_DUAL_IO: data_lanes = sfsp_lane_2;
      `SFSP_OP_QUAD_OUT, `SFSP_OP_QUAD_IO: data_lanes = sfsp_lane_4;
      default: data_lanes = sfsp_lane_1;
    endcase
  endfunction

  function automatic logic [5:0] addr_end(input logic [7:0] op);
    case (addr_lanes(op))
      sfsp_lane_2: addr_end = `SFSP_ADDR_END_2;
      sfsp_lane_4: addr_end = `SFSP_ADDR_END_4;
      default: addr_end = `SFSP_CNT_ADDR;
    endcase
  endfunction

  function automatic logic [5:0] hdr_len(input logic [7:0] op);
    case (op)
      `SFSP_OP_READ: hdr_len = `SFSP_HDR_READ;
      `SFSP_OP_FAST_READ, `SFSP_OP_DUAL_OUT, `SFSP_OP_QUAD_OUT: hdr_len = `SFSP_HDR_FAST;
      `SFSP_OP_DUAL_IO: hdr_len = `SFSP_HDR_DUAL_IO;
      `SFSP_OP_QUAD_IO: hdr_len = `SFSP_HDR_QUAD_IO;
      default: hdr_len = `SFSP_HDR_STATUS;
    endcase
  endfunction

  function automatic logic [3:0] lane_pick(input logic [7:0] b, input sfsp_lanes_t w,
                                           input logic [2:0] p);
    logic [3:0] r;
    r = 4'h0;
    case (w)
      sfsp_lane_2: begin
        r[1] = b[{~p[1:0], 1'b1}]; // [R1]
        r[0] = b[{~p[1:0], 1'b0}]; // [R1]
      end
      sfsp_lane_4: r = p[0] ? b[3:0] : b[7:4]; // [R3] [R5]
      default: r[1] = b[~p]; // [R27]
    endcase
    return r;
  endfunction

  function automatic logic [3:0] lane_enables(input sfsp_lanes_t w);
    case (w)
      sfsp_lane_2: lane_enables = 4'h3;
      sfsp_lane_4: lane_enables = 4'hf;
      default: lane_enables = 4'h2;
    endcase
  endfunction

  function automatic logic [2:0] last_pos(input sfsp_lanes_t w);
    case (w)
      sfsp_lane_2: last_pos = 3'h3;
      sfsp_lane_4: last_pos = 3'h1;
      default: last_pos = 3'h7;
    endcase
  endfunction

  // Returns 1..3 for a security register, 0 when the address hits none.
  function automatic logic [1:0] sec_index(input logic [23:0] a);
    sec_index = 2'h0;
    if (a[23:16] == `SFSP_SEC_HIGH) begin // [R6]
      case (a[15:9])
        `SFSP_SEC_REG1: sec_index = 2'h1;
        `SFSP_SEC_REG2: sec_index = 2'h2;
        `SFSP_SEC_REG3: sec_index = 2'h3;
        default: sec_index = 2'h0;
      endcase
    end
  endfunction

  // Lock bits only ever accumulate ones; other fields follow the mask.
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] val,
                                        input logic [15:0] mask);
    logic [15:0] r;
    r = (old & ~mask) | (val & mask); // [R26]
    r[`SFSP_FLD_LOCK] = old[`SFSP_FLD_LOCK] | r[`SFSP_FLD_LOCK]; // [R22]
    return r;
  endfunction

  // Status snapshot held steady for the link while a frame is open.
  logic [15:0] snap_reg;

  // Link domain. The frame registers are not reset: they only ever hold the
  // last frame, and the system side reads them only after a fresh frame ended.
  logic first_reg;
  logic seq_reg;
  logic [5:0] cnt_reg;
  logic [7:0] cmd_reg;
  logic [15:0] wd_reg;
  logic [31:0] am_reg;
  logic [2:0] dpos_reg;
  logic [23:0] bidx_reg;
  logic hold_act;
  logic [23:0] rd_base;
  logic in_data;
  logic rd_ok;
  sfsp_lanes_t out_w;
  logic [7:0] out_byte;

  assign hold_act = ~snap_reg[`SFSP_BIT_QUAD] & ~io_in[3]; // [R21]
  assign rd_base = (addr_lanes(cmd_reg) == sfsp_lane_1) ? am_reg[23:0] : am_reg[31:8];
  assign array_addr = rd_base + bidx_reg;
  assign in_data = ~first_reg & (cnt_reg >= hdr_len(cmd_reg));
  assign out_w = data_lanes(cmd_reg);

  always_comb begin
    rd_ok = 1'b0;
    out_byte = array_byte;
    case (cmd_reg)
      `SFSP_OP_STATUS_LO: begin
        rd_ok = 1'b1; // [R10]
        out_byte = snap_reg[7:0];
      end
      `SFSP_OP_STATUS_HI: begin
        rd_ok = 1'b1; // [R10]
        out_byte = snap_reg[15:8];
      end
      `SFSP_OP_READ, `SFSP_OP_FAST_READ, `SFSP_OP_DUAL_OUT, `SFSP_OP_DUAL_IO:
        rd_ok = ~snap_reg[`SFSP_BIT_BUSY];
      `SFSP_OP_QUAD_OUT, `SFSP_OP_QUAD_IO:
        rd_ok = ~snap_reg[`SFSP_BIT_BUSY] & snap_reg[`SFSP_BIT_QUAD]; // [R21]
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      first_reg <= 1'b1;
    end else if (!hold_act) begin
      first_reg <= 1'b0;
    end
  end

  // Cleared by the system reset while the link clock stands still, so the first
  // frame's toggle starts from a known level and the system side can see it.
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      seq_reg <= 1'b0;
    end else if (!cs_n && !hold_act && first_reg) begin
      seq_reg <= ~seq_reg;
    end
  end

  always_ff @(posedge sclk) begin
    if (!cs_n && !hold_act) begin
      if (first_reg) begin
        cnt_reg <= 6'h01;
      end else if (cnt_reg != `SFSP_CNT_MAX) begin
        cnt_reg <= cnt_reg + 6'h01;
      end
    end
  end

  always_ff @(posedge sclk) begin
    if (!cs_n && !hold_act) begin
      if (first_reg) begin
        cmd_reg <= {7'h00, io_in[0]};
      end else if (cnt_reg < `SFSP_CNT_OPCODE) begin
        cmd_reg <= {cmd_reg[6:0], io_in[0]};
      end
    end
  end

  always_ff @(posedge sclk) begin
    if (!cs_n && !hold_act && !first_reg) begin
      if (cnt_reg >= `SFSP_CNT_OPCODE && cnt_reg < `SFSP_CNT_WR16) begin
        wd_reg <= {wd_reg[14:0], io_in[0]};
      end
      if (cnt_reg >= `SFSP_CNT_OPCODE && cnt_reg < addr_end(cmd_reg)) begin
        case (addr_lanes(cmd_reg))
          sfsp_lane_2: am_reg <= {am_reg[29:0], io_in[1:0]}; // [R2]
          sfsp_lane_4: am_reg <= {am_reg[27:0], io_in[3:0]}; // [R4]
          default: am_reg <= {am_reg[30:0], io_in[0]};
        endcase
      end
    end
  end

  always_ff @(posedge sclk) begin
    if (!cs_n && !hold_act) begin
      if (first_reg) begin
        dpos_reg <= 3'h0;
        bidx_reg <= 24'h000000;
      end else if (in_data) begin
        if (dpos_reg == last_pos(out_w)) begin
          dpos_reg <= 3'h0;
          bidx_reg <= bidx_reg + 24'h000001;
        end else begin
          dpos_reg <= dpos_reg + 3'h1;
        end
      end
    end
  end

  // Data leaves on the falling edge so the host can sample on the rising one.
  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      io_out <= 4'h0;
      io_oe <= 4'h0;
    end else if (!hold_act && in_data && rd_ok) begin
      io_out <= lane_pick(out_byte, out_w, dpos_reg); // [R1] [R3]
      io_oe <= lane_enables(out_w); // [R5] [R27]
    end else begin
      io_oe <= 4'h0;
    end
  end

  // System domain.
  logic [2:0] cs_sync_reg;
  logic [1:0] seq_sync_reg;
  logic [1:0] wp_sync_reg;
  logic seq_seen_reg;
  sfsp_state_t state_reg;
  logic [TW_W-1:0] tw_cnt_reg;
  logic write_enable_latch_reg;
  logic vol_arm_reg;
  logic reset_arm_reg;
  logic erase_suspended_reg;
  logic program_suspended_reg;
  logic op_is_erase_reg;
  logic [15:0] cfg_reg;
  logic [15:0] nv_reg;
  logic [15:0] pend_reg;
  logic busy_flag;
  logic ev;
  logic n8;
  logic sr_open;
  logic [15:0] wr_val;
  logic [15:0] wr_mask;
  logic cmd_wen;
  logic cmd_wdis;
  logic cmd_vol;
  logic cmd_srw;
  logic cmd_op;
  logic cmd_susp;
  logic cmd_res;
  logic cmd_rst;
  logic op_erase;
  logic srw_done;
  logic op_fin;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cs_sync_reg <= 3'h7;
      seq_sync_reg <= 2'h0;
      wp_sync_reg <= 2'h3;
    end else begin
      cs_sync_reg <= {cs_sync_reg[1:0], cs_n};
      seq_sync_reg <= {seq_sync_reg[0], seq_reg};
      wp_sync_reg <= {wp_sync_reg[0], io_in[2]};
    end
  end

  // A frame counts only if its sequence toggle moved, so an empty select
  // pulse cannot replay the previous command.
  assign ev = cs_sync_reg[1] & ~cs_sync_reg[2] & (seq_sync_reg[1] != seq_seen_reg) &
              (cnt_reg >= `SFSP_CNT_OPCODE);
  assign n8 = (cnt_reg == `SFSP_CNT_OPCODE);
  assign busy_flag = (state_reg == sfsp_array) | (state_reg == sfsp_srw); // [R13]

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      seq_seen_reg <= 1'b0;
    end else if (cs_sync_reg[1] & ~cs_sync_reg[2]) begin
      seq_seen_reg <= seq_sync_reg[1];
    end
  end

  always_comb begin
    case ({cfg_reg[`SFSP_BIT_PM_HI], cfg_reg[`SFSP_BIT_PM_LO]})
      2'h0: sr_open = 1'b1; // [R17]
      2'h1: sr_open = wp_sync_reg[1] | cfg_reg[`SFSP_BIT_QUAD]; // [R18] [R21]
      2'h2: sr_open = 1'b0; // [R19]
      default: sr_open = 1'b0; // [R20]
    endcase
  end

  assign wr_val = (cnt_reg == `SFSP_CNT_WR16) ? {wd_reg[7:0], wd_reg[15:8]} :
                  {8'h00, wd_reg[7:0]};
  assign wr_mask = (cnt_reg == `SFSP_CNT_WR16) ? `SFSP_WMASK_16 : `SFSP_WMASK_8; // [R25]

  always_comb begin
    cmd_wen = 1'b0;
    cmd_wdis = 1'b0;
    cmd_vol = 1'b0;
    cmd_srw = 1'b0;
    cmd_op = 1'b0;
    cmd_susp = 1'b0;
    cmd_res = 1'b0;
    cmd_rst = 1'b0;
    op_erase = 1'b0;
    if (ev) begin
      case (cmd_reg)
        `SFSP_OP_WRITE_ENABLE: cmd_wen = n8 & ~busy_flag; // [R24] [R11]
        `SFSP_OP_WRITE_DISABLE: cmd_wdis = n8 & ~busy_flag; // [R8]
        `SFSP_OP_VOL_ENABLE: cmd_vol = n8 & ~busy_flag; // [R7]
        `SFSP_OP_STATUS_WRITE:
          cmd_srw = ((cnt_reg == `SFSP_CNT_WR8) | (cnt_reg == `SFSP_CNT_WR16)) & // [R25]
                    (state_reg == sfsp_idle) & sr_open & // [R15]
                    (write_enable_latch_reg | vol_arm_reg); // [R14] [R7]
        `SFSP_OP_PAGE_PROG, `SFSP_OP_DUAL_PROG, `SFSP_OP_QUAD_PROG:
          cmd_op = (cnt_reg > `SFSP_CNT_ADDR) & write_enable_latch_reg & // [R14]
                   (state_reg == sfsp_idle);
        `SFSP_OP_PAGE_ERASE, `SFSP_OP_SECTOR_ERASE, `SFSP_OP_BLK32_ERASE,
        `SFSP_OP_BLK64_ERASE: begin
          cmd_op = (cnt_reg == `SFSP_CNT_ADDR) & write_enable_latch_reg & // [R14]
                   (state_reg == sfsp_idle);
          op_erase = 1'b1;
        end
        `SFSP_OP_CHIP_ERASE_A, `SFSP_OP_CHIP_ERASE_B: begin
          cmd_op = n8 & write_enable_latch_reg & (state_reg == sfsp_idle) &
                   (cfg_reg[`SFSP_FLD_BP] == 5'h00); // [R16]
          op_erase = 1'b1;
        end
        `SFSP_OP_SECURE_ERASE, `SFSP_OP_SECURE_PROG: begin
          cmd_op = ((cmd_reg == `SFSP_OP_SECURE_ERASE) ? (cnt_reg == `SFSP_CNT_ADDR) :
                    (cnt_reg > `SFSP_CNT_ADDR)) &
                   write_enable_latch_reg & (state_reg == sfsp_idle) & // [R14]
                   (sec_index(am_reg[23:0]) != 2'h0) &
                   ~cfg_reg[`SFSP_BIT_LATCH + 9 + sec_index(am_reg[23:0])]; // [R6] [R22]
          op_erase = (cmd_reg == `SFSP_OP_SECURE_ERASE);
        end
        `SFSP_OP_SUSPEND_A, `SFSP_OP_SUSPEND_B: cmd_susp = n8 & (state_reg == sfsp_array);
        `SFSP_OP_RESUME_A, `SFSP_OP_RESUME_B: cmd_res = n8 & (state_reg == sfsp_susp);
        `SFSP_OP_RESET: cmd_rst = n8 & reset_arm_reg & ~busy_flag;
        default: cmd_wen = 1'b0;
      endcase
    end
  end

  assign srw_done = (state_reg == sfsp_srw) & (tw_cnt_reg == '0);
  assign op_fin = (state_reg == sfsp_array) & op_done;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_reg <= sfsp_idle;
      tw_cnt_reg <= '0;
    end else begin
      case (state_reg)
        sfsp_idle: begin
          if (cmd_srw && !vol_arm_reg) begin
            state_reg <= sfsp_srw;
            tw_cnt_reg <= TW_W'(TW_CYCLES - 1);
          end else if (cmd_op) begin
            state_reg <= sfsp_array;
          end
        end
        sfsp_srw: begin
          if (srw_done) begin
            state_reg <= sfsp_idle;
          end else begin
            tw_cnt_reg <= tw_cnt_reg - TW_W'(1);
          end
        end
        sfsp_array: begin
          if (op_fin) begin
            state_reg <= sfsp_idle;
          end else if (cmd_susp) begin
            state_reg <= sfsp_susp;
          end
        end
        sfsp_susp: begin
          if (cmd_res) begin
            state_reg <= sfsp_array;
          end
        end
        default: state_reg <= sfsp_idle;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      write_enable_latch_reg <= 1'b0; // [R9]
    end else if (cmd_wdis || cmd_rst || srw_done || op_fin || (cmd_srw && vol_arm_reg)) begin
      write_enable_latch_reg <= 1'b0; // [R8] [R9]
    end else if (cmd_wen) begin
      write_enable_latch_reg <= 1'b1; // [R24]
    end
  end

  // The volatile arm lasts for exactly one status-write frame, taken or not.
  always_ff @(posedge clk) begin
    if (!rst_n || cmd_rst) begin
      vol_arm_reg <= 1'b0;
    end else if (cmd_vol) begin
      vol_arm_reg <= 1'b1; // [R7]
    end else if (ev && cmd_reg == `SFSP_OP_STATUS_WRITE) begin
      vol_arm_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reset_arm_reg <= 1'b0;
    end else if (ev) begin
      reset_arm_reg <= n8 & (cmd_reg == `SFSP_OP_RESET_ENABLE);
    end
  end

  // Flops stand in for the non-volatile cells, so reset doubles as the power
  // cycle: protect mode 10 falls back to 00 here, but so does 11.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cfg_reg <= `SFSP_STATUS_RESET; // [R19] [R23]
      nv_reg <= `SFSP_STATUS_RESET;
      pend_reg <= `SFSP_STATUS_RESET;
    end else if (cmd_rst) begin
      cfg_reg <= nv_reg;
    end else if (cmd_srw && vol_arm_reg) begin
      cfg_reg <= merge(cfg_reg, wr_val, wr_mask); // [R7]
    end else if (cmd_srw) begin
      pend_reg <= merge(cfg_reg, wr_val, wr_mask); // [R15] [R22]
    end else if (srw_done) begin
      cfg_reg <= pend_reg;
      nv_reg <= pend_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      erase_suspended_reg <= 1'b0;
      program_suspended_reg <= 1'b0;
    end else if (cmd_res) begin
      erase_suspended_reg <= 1'b0;
      program_suspended_reg <= 1'b0;
    end else if (cmd_susp) begin
      erase_suspended_reg <= op_is_erase_reg;
      program_suspended_reg <= ~op_is_erase_reg;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      op_start <= 1'b0;
      op_code <= 8'h00;
      op_addr <= 24'h000000;
      op_is_erase_reg <= 1'b0;
    end else begin
      op_start <= cmd_op;
      if (cmd_op) begin
        op_code <= cmd_reg;
        op_addr <= am_reg[23:0];
        op_is_erase_reg <= op_erase;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      status_word <= `SFSP_STATUS_RESET;
      op_suspend <= 1'b0;
    end else begin
      status_word <= {erase_suspended_reg, cfg_reg[14:11], program_suspended_reg, // [R12]
                      cfg_reg[9:2], write_enable_latch_reg, busy_flag};
      op_suspend <= (state_reg == sfsp_susp);
    end
  end

  // Updated only while select is high, so a status read sees one steady word.
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      snap_reg <= `SFSP_STATUS_RESET;
    end else if (cs_sync_reg[1]) begin
      snap_reg <= {erase_suspended_reg, cfg_reg[14:11], program_suspended_reg,
                   cfg_reg[9:2], write_enable_latch_reg, busy_flag}; // [R13]
    end
  end
endmodule

// ### sim/sfsp_checker_assertions.sv
`timescale 1ns/1ps
module sfsp_checker #(
  parameter int unsigned TW_CYCLES = 20
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic [3:0] io_in,
  input wire logic [3:0] io_out,
  input wire logic [3:0] io_oe,
  input wire logic [23:0] array_addr,
  input wire logic [7:0] array_byte,
  input wire logic op_start,
  input wire logic [7:0] op_code,
  input wire logic [23:0] op_addr,
  input wire logic op_suspend,
  input wire logic op_done,
  input wire logic [15:0] status_word
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  logic [31:0] busy_cnt;
  logic op_run;
  // An array operation may stay busy for any time, so only status writes get a bound.
  always_ff @(posedge clk) begin
    if (!rst_n || !status_word[0] || op_done)
      busy_cnt <= 32'h0;
    else
      busy_cnt <= busy_cnt + 32'h1;
  end
  always_ff @(posedge clk) begin
    if (!rst_n || op_done)
      op_run <= 1'b0;
    else if (op_start)
      op_run <= 1'b1;
  end
  AST_POWER_UP: assert property (disable iff (1'b0) !rst_n |=> status_word == 16'h0000)
    else $error("status not cleared by reset");
  AST_LATCH_BEFORE_OP: assert property (op_start |-> $past(status_word[1], 2))
    else $error("operation accepted without latch");
  AST_IDLE_BEFORE_OP: assert property (op_start |-> !$past(status_word[0], 2))
    else $error("operation accepted while busy");
  AST_BUSY_AFTER_OP: assert property (op_start |-> ##[1:3] status_word[0])
    else $error("busy not raised");
  AST_DONE_CLEARS: assert property (op_run && op_done |-> ##[1:4] status_word[1:0] == 2'h0)
    else $error("busy or latch left after completion");
  AST_SUSPEND_BITS: assert property (!op_suspend [*5] |-> $stable({status_word[15], status_word[10]}))
    else $error("suspend bits moved");
  AST_OE_IDLE: assert property (cs_n |-> io_oe == 4'h0)
    else $error("lane driven outside frame");
  AST_OE_LANES: assert property (io_oe inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("illegal lane set");
  AST_QUAD_NEEDS_QE: assert property (io_oe == 4'hf |-> status_word[9])
    else $error("quad output without quad enable");
  AST_CHIP_ERASE: assert property (op_start && op_code inside {8'h60, 8'hc7} |-> status_word[6:2] == 5'h00)
    else $error("chip erase with protected area");
  AST_WRITE_BUSY_LEN: assert property (status_word[0] |-> op_run || busy_cnt <= TW_CYCLES + 8)
    else $error("status write busy too long");
endmodule

bind sfsp_status_protect sfsp_checker #(.TW_CYCLES(TW_CYCLES)) i_sfsp_checker (
  .clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
  .io_oe(io_oe), .array_addr(array_addr), .array_byte(array_byte), .op_start(op_start),
  .op_code(op_code), .op_addr(op_addr), .op_suspend(op_suspend), .op_done(op_done),
  .status_word(status_word)
);

// ### sim/sfsp_host.sv
`timescale 1ns/1ps
module sfsp_host (
  output logic sclk,
  output logic cs_n,
  output logic [3:0] host_io,
  input wire logic wp_n,
  input wire logic [3:0] io_out
);
  logic d0 = 1'b0;
  // Select rises once after time zero, so the flops that it clears start known.
  initial begin
    sclk = 1'b0;
    cs_n = 1'b0;
    #1 cs_n = 1'b1;
  end
  // Hold stays inactive; lane 1 is never ours, so it toggles instead of keeping a level.
  assign host_io = {1'b1, wp_n, ~sclk, d0};
  task automatic xfer(input logic [7:0] op, input logic [31:0] tx, input int ntx,
      input int nrx, input bit dual, output logic [31:0] rx);
    logic [39:0] sh;
    sh = {op, tx << (32 - ntx)};
    rx = 32'h0;
    cs_n = 1'b0;
    #45;
    for (int i = 0; i < 8 + ntx + nrx; i++) begin
      d0 = sh[39];
      sh = sh << 1;
      #7.5;
      if (i >= 8 + ntx)
        rx = dual ? {rx[29:0], io_out[1:0]} : {rx[30:0], io_out[1]};
      sclk = 1'b1;
      #7.5;
      sclk = 1'b0;
    end
    #20;
    cs_n = 1'b1;
    d0 = ~d0;
    #250;
  endtask
endmodule

// ### sim/testbench.sv
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [7:0] op;
    logic [15:0] d;
    logic [4:0] n;
    logic wp;
    logic [15:0] exp;
  } sfsp_row_t;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wp_n = 1'b1;
  logic op_done = 1'b0;
  logic sclk, cs_n, op_start, op_suspend;
  logic [3:0] host_io, io_in, io_out, io_oe;
  logic [23:0] array_addr, op_addr;
  logic [7:0] array_byte, op_code;
  logic [15:0] status_word;
  logic [31:0] rx;
  int fail_count = 0;
  int tests_run = 0;
  int starts = 0;
  int n0;
  sfsp_row_t rows [17] = '{
    '{8'h06, 16'h0000, 5'h00, 1'h1, 16'h0002},
    '{8'h04, 16'h0000, 5'h00, 1'h1, 16'h0000},
    '{8'h01, 16'h0210, 5'h10, 1'h1, 16'h0000},
    '{8'h06, 16'h0000, 5'h00, 1'h1, 16'h0002},
    '{8'h01, 16'h0210, 5'h10, 1'h1, 16'h0210},
    '{8'h06, 16'h0000, 5'h00, 1'h1, 16'h0212},
    '{8'h01, 16'h0abc, 5'h0c, 1'h1, 16'h0212},
    '{8'h01, 16'h0000, 5'h08, 1'h1, 16'h0200},
    '{8'h50, 16'h0000, 5'h00, 1'h1, 16'h0200},
    '{8'h01, 16'h0084, 5'h10, 1'h1, 16'h0084},
    '{8'h06, 16'h0000, 5'h00, 1'h1, 16'h0086},
    '{8'h01, 16'h0000, 5'h10, 1'h0, 16'h0086},
    '{8'h01, 16'h0800, 5'h10, 1'h1, 16'h0800},
    '{8'h06, 16'h0000, 5'h00, 1'h1, 16'h0802},
    '{8'h01, 16'h0100, 5'h10, 1'h1, 16'h0900},
    '{8'h06, 16'h0000, 5'h00, 1'h1, 16'h0902},
    '{8'h01, 16'h0000, 5'h10, 1'h1, 16'h0902}
  };
  always #5 clk = ~clk;
  assign io_in = (io_oe & io_out) | (~io_oe & host_io);
  assign array_byte = array_addr[7:0] ^ 8'h5a;
  always @(posedge clk) begin
    if (op_start === 1'b1)
      starts++;
  end
  sfsp_status_protect #(.TW_CYCLES(20)) i_sfsp_status_protect (
    .clk(clk), .rst_n(rst_n), .sclk(sclk), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .array_addr(array_addr), .array_byte(array_byte), .op_start(op_start),
    .op_code(op_code), .op_addr(op_addr), .op_suspend(op_suspend), .op_done(op_done),
    .status_word(status_word));
  sfsp_host i_sfsp_host (.sclk(sclk), .cs_n(cs_n), .host_io(host_io), .wp_n(wp_n),
    .io_out(io_in));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // The first status byte goes out first, so a full write is byte swapped on the wire.
  task automatic frame(input logic [7:0] op, input logic [15:0] d, input int n);
    int k;
    i_sfsp_host.xfer(op, n == 16 ? {d[7:0], d[15:8]} : d, n, 0, 1'b0, rx);
    k = 0;
    while (status_word[0] !== 1'b0 && k < 200) begin
      @(posedge clk);
      k++;
    end
    check("busy clear", status_word[0], 1'b0);
  endtask
  task automatic read_status(input logic [15:0] exp);
    i_sfsp_host.xfer(8'h05, 32'h0, 0, 8, 1'b0, rx);
    check("status low", rx, {24'h0, exp[7:0]});
    i_sfsp_host.xfer(8'h35, 32'h0, 0, 8, 1'b0, rx);
    check("status high", rx, {24'h0, exp[15:8]});
    check("status word", status_word, exp);
  endtask
  initial begin
    #200000;
    fail_count++;
    wrap_up;
  end
  initial begin
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    read_status(16'h0000);
    foreach (rows[i]) begin
      @(posedge clk);
      #1 wp_n = rows[i].wp;
      frame(rows[i].op, rows[i].d, rows[i].n);
      read_status(rows[i].exp);
    end
    @(posedge clk);
    #1 rst_n = 1'b0;
    repeat (2) @(posedge clk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge clk);
    read_status(16'h0000);
    frame(8'h06, 16'h0000, 0);
    frame(8'h01, 16'h0004, 16);
    frame(8'h06, 16'h0000, 0);
    n0 = starts;
    frame(8'h60, 16'h0000, 0);
    check("chip erase start", starts - n0, 0);
    frame(8'h01, 16'h0000, 16);
    frame(8'h06, 16'h0000, 0);
    i_sfsp_host.xfer(8'h20, 32'h012345, 24, 0, 1'b0, rx);
    check("erase start", starts - n0, 1);
    check("erase code", op_code, 8'h20);
    check("erase addr", op_addr, 24'h012345);
    read_status(16'h0003);
    @(posedge clk);
    #1 op_done = 1'b1;
    @(posedge clk);
    #1 op_done = 1'b0;
    repeat (6) @(posedge clk);
    read_status(16'h0000);
    frame(8'h06, 16'h0000, 0);
    frame(8'h01, 16'h0180, 16);
    frame(8'h06, 16'h0000, 0);
    frame(8'h01, 16'h0000, 16);
    read_status(16'h0182);
    i_sfsp_host.xfer(8'h3b, 32'h00010000, 32, 4, 1'b1, rx);
    check("dual byte", rx, 32'h5a);
    frame(8'h66, 16'h0000, 0);
    frame(8'h99, 16'h0000, 0);
    read_status(16'h0180);
    wrap_up;
  end
endmodule
